// >>> common/tcco_consts.svh
// Constants for the trip cause code output block.
// Assumes inclusion by the package and by the design files.
`ifndef TCCO_CONSTS_SVH
`define TCCO_CONSTS_SVH

// ********************************
// Register map (word addresses)
// ********************************
`define TCCO_ADDR_WIDTH_SEL 4'h0
`define TCCO_ADDR_TRIP 4'h1
`define TCCO_ADDR_STATUS 4'h2
`define TCCO_ADDR_MASK 4'h3
`define TCCO_ADDR_CODE 4'h4
`define TCCO_ADDR_TERM 4'h5

// ********************************
// Width select values
// ********************************
`define TCCO_SEL_OFF 8'h00
`define TCCO_SEL_3BIT 8'h01
`define TCCO_SEL_4BIT 8'h02
`define TCCO_SEL_RST 8'h00

// ********************************
// Status bit positions
// ********************************
`define TCCO_ST_TRIP 0
`define TCCO_ST_CLEAR 1
`define TCCO_ST_BITS 2

// ********************************
// Trip cause encoding (factor number)
// ********************************
`define TCCO_CAUSE_W 7
`define TCCO_CAUSE_NONE 7'h00
`define TCCO_CODE_OTHER3 4'h7

`endif

// >>> common/tcco_pkg.sv
// Types of the trip cause code output block.
// Assumes the constants header is on the include path.
`include "tcco_consts.svh"

package tcco_pkg;
  typedef enum logic [1:0] {
    TCCO_MODE_OFF = 2'b00,
    TCCO_MODE_3BIT = 2'b01,
    TCCO_MODE_4BIT = 2'b10
  } tcco_mode_t;

  typedef logic [3:0] tcco_code_t;
endpackage

// >>> verilog/tcco_encoder.sv
// Combinational map from trip factor number to 3- or 4-bit category code.
// Assumes the cause number is held stable by the caller.
`include "tcco_consts.svh"

module tcco_encoder (
  input wire logic [`TCCO_CAUSE_W-1:0] cause_in,
  input wire tcco_pkg::tcco_mode_t mode_in,
  output tcco_pkg::tcco_code_t code_out
);
  import tcco_pkg::*;

  function automatic tcco_code_t cat4(input logic [`TCCO_CAUSE_W-1:0] c);
    tcco_code_t r;
    r = 4'h0;
    case (c)
      7'h01, 7'h02, 7'h03, 7'h04: r = 4'h1;
      7'h05, 7'h26: r = 4'h2;
      7'h07, 7'h0f: r = 4'h3;
      7'h09: r = 4'h4;
      7'h10: r = 4'h5;
      7'h1e: r = 4'h6;
      7'h06: r = 4'h7;
      7'h08, 7'h0b, 7'h17, 7'h19: r = 4'h8;
      7'h0a: r = 4'h9;
      7'h0c, 7'h0d, 7'h23, 7'h24: r = 4'ha;
      7'h0e: r = 4'hb;
      7'h2b, 7'h2c, 7'h2d: r = 4'hc;
      7'h14, 7'h15: r = 4'hd;
      7'h18: r = 4'he;
      default: begin
        if (c >= 7'h32 && c <= 7'h4f) begin
          r = 4'hf;
        end
      end
    endcase
    return r;
  endfunction

  tcco_code_t full;

  always_comb begin
    full = cat4(cause_in);
    code_out = 4'h0;
    case (mode_in)
      TCCO_MODE_4BIT: code_out = full;
      TCCO_MODE_3BIT: begin
        // Low-speed overload shares code 2 in both widths
        if (cause_in == `TCCO_CAUSE_NONE) begin
          code_out = 4'h0;
        end else if (full >= 4'h1 && full <= 4'h6) begin
          code_out = full;
        end else begin
          code_out = `TCCO_CODE_OTHER3;
        end
      end
      default: code_out = 4'h0;
    endcase
  end
endmodule

// >>> verilog/tcco_top.sv
// Trip cause code output: drives the trip category onto output terminals.
// Assumes a classic Wishbone master and a trip detector on the same clock.
//
// Contract
// - Width select 00 disables output, 01 selects 3 bits, 02 selects 4.
// - Enabled output overrides terminals 11-13 (3 bits) or 11-14 (4 bits).
// - After a trip the terminals carry the binary category of the cause.
// - Codes 1-6 are overcurrent, overload, overvoltage, undervoltage, power failure, switch error.
// - In 4-bit mode code 7 is braking resistor overload.
// - In 4-bit mode code 8 is memory, processor, gate-array or main circuit error.
// - In 4-bit mode codes 9, 10 and 11 are sensor, external-type and ground faults.
// - In 4-bit mode code 12 is any built-in sequence program fault.
// - In 4-bit mode code 13 is over-temperature, fan-related included.
// - In 4-bit mode code 14 is input phase loss.
// - In 4-bit mode code 15 is a user sequence trip or option board error.
//
// Register access over Wishbone and the register addresses are this design's own decisions.
`include "tcco_consts.svh"

module tcco_top (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [3:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic trip_in,
  input wire logic [`TCCO_CAUSE_W-1:0] trip_cause_in,
  input wire logic trip_reset_in,
  input wire logic [4:0] term_func_in,
  output logic [4:0] term_out,
  output logic irq_out
);
  import tcco_pkg::*;

  // ********************************
  // Register bus
  // ********************************
  logic ack_q;
  logic [7:0] width_sel_q;
  logic [`TCCO_ST_BITS-1:0] status_q;
  logic [`TCCO_ST_BITS-1:0] mask_q;
  logic [`TCCO_CAUSE_W-1:0] cause_q;
  logic tripped_q;
  logic [4:0] term_q;
  logic [3:0] code_q;
  tcco_mode_t mode;
  tcco_code_t enc_code;
  logic bus_req;
  logic wr_ev;
  logic trip_ev;
  logic clear_ev;

  assign bus_req = wb_cyc_in & wb_stb_in & ~ack_q;
  // A write lands at the edge where the master sees ack high
  assign wr_ev = wb_cyc_in & wb_stb_in & ack_q & wb_we_in & wb_sel_in[0];
  assign wb_ack_out = ack_q;

  // One wait state: ack in the cycle after the request is seen
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req;
    end
  end

  function automatic logic [31:0] rd_mux(input logic [3:0] a);
    logic [31:0] r;
    r = 32'h0;
    case (a)
      `TCCO_ADDR_WIDTH_SEL: r[7:0] = width_sel_q;
      `TCCO_ADDR_TRIP: r = {24'h0, tripped_q, cause_q};
      `TCCO_ADDR_STATUS: r[`TCCO_ST_BITS-1:0] = status_q;
      `TCCO_ADDR_MASK: r[`TCCO_ST_BITS-1:0] = mask_q;
      `TCCO_ADDR_CODE: r[3:0] = code_q;
      `TCCO_ADDR_TERM: r[4:0] = term_q;
      default: r = 32'h0;
    endcase
    return r;
  endfunction

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wb_dat_out <= 32'h0;
    end else if (bus_req && !wb_we_in) begin
      wb_dat_out <= rd_mux(wb_adr_in);
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      width_sel_q <= `TCCO_SEL_RST;
    end else if (wr_ev && wb_adr_in == `TCCO_ADDR_WIDTH_SEL) begin
      width_sel_q <= wb_dat_in[7:0];
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mask_q <= '0;
    end else if (wr_ev && wb_adr_in == `TCCO_ADDR_MASK) begin
      mask_q <= wb_dat_in[`TCCO_ST_BITS-1:0];
    end
  end

  // ********************************
  // Mode decode
  // ********************************
  // Values above 02 are treated as off rather than guessed at
  always_comb begin
    case (width_sel_q)
      `TCCO_SEL_3BIT: mode = TCCO_MODE_3BIT;
      `TCCO_SEL_4BIT: mode = TCCO_MODE_4BIT;
      default: mode = TCCO_MODE_OFF;
    endcase
  end

  // ********************************
  // Trip capture
  // ********************************
  assign trip_ev = trip_in & ~tripped_q;
  assign clear_ev = trip_reset_in & tripped_q & ~trip_in;

  // The first cause is latched; later trips cannot overwrite it
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tripped_q <= 1'b0;
      cause_q <= `TCCO_CAUSE_NONE;
    end else if (trip_ev) begin
      tripped_q <= 1'b1;
      cause_q <= trip_cause_in;
    end else if (clear_ev) begin
      tripped_q <= 1'b0;
      cause_q <= `TCCO_CAUSE_NONE;
    end
  end

  tcco_encoder u_enc (
    .cause_in(cause_q),
    .mode_in(mode),
    .code_out(enc_code)
  );

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      code_q <= 4'h0;
    end else begin
      code_q <= tripped_q ? enc_code : 4'h0;
    end
  end

  // ********************************
  // Terminal override
  // ********************************
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      term_q <= 5'h0;
    end else begin
      case (mode)
        TCCO_MODE_3BIT: term_q <= {term_func_in[4:3], code_q[2:0]};
        TCCO_MODE_4BIT: term_q <= {term_func_in[4], code_q};
        default: term_q <= term_func_in;
      endcase
    end
  end
  assign term_out = term_q;

  // ********************************
  // Interrupts
  // ********************************
  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      status_q <= '0;
    end else begin
      if (wr_ev && wb_adr_in == `TCCO_ADDR_STATUS) begin
        status_q <= status_q & ~wb_dat_in[`TCCO_ST_BITS-1:0]
                    | {clear_ev, trip_ev};
      end else begin
        status_q <= status_q | {clear_ev, trip_ev};
      end
    end
  end
  assign irq_out = |(status_q & mask_q);

  // ********************************
  // Checks
  // ********************************
  AST_OFF_PASSES: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (width_sel_q == `TCCO_SEL_OFF) |=> term_out == $past(term_func_in))
    else $error("terminals not passed through while off");

  AST_3BIT_OVR: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (width_sel_q == `TCCO_SEL_3BIT) |=>
      term_out[2:0] == $past(code_q[2:0]) &&
      term_out[4:3] == $past(term_func_in[4:3]))
    else $error("3-bit override wrong");

  AST_4BIT_OVR: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (width_sel_q == `TCCO_SEL_4BIT) |=>
      term_out[3:0] == $past(code_q) && term_out[4] == $past(term_func_in[4]))
    else $error("4-bit override wrong");

  sequence s_trip_settled;
    trip_ev ##1 tripped_q [*2];
  endsequence

  AST_TRIP_CODE: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    s_trip_settled |-> code_q == $past(enc_code))
    else $error("code not presented after trip");

  AST_IDLE_ZERO: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    !tripped_q |=> code_q == 4'h0)
    else $error("code nonzero without trip");

  AST_3BIT_OTHER: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (mode == TCCO_MODE_3BIT && cause_q == 7'h06) |-> enc_code == 4'h7)
    else $error("3-bit other code wrong");

  AST_4BIT_BRAKE: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (mode == TCCO_MODE_4BIT && cause_q == 7'h06) |-> enc_code == 4'h7)
    else $error("braking code wrong");

  AST_4BIT_PHASE: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (mode == TCCO_MODE_4BIT && cause_q == 7'h18) |-> enc_code == 4'he)
    else $error("phase loss code wrong");

  AST_4BIT_USER: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (mode == TCCO_MODE_4BIT && cause_q == 7'h40) |-> enc_code == 4'hf)
    else $error("user trip code wrong");

  AST_UV: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (mode != TCCO_MODE_OFF && cause_q == 7'h09) |-> enc_code == 4'h4)
    else $error("undervoltage code wrong");

  AST_4BIT_OC: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (mode == TCCO_MODE_4BIT && cause_q == 7'h02) |-> enc_code == 4'h1)
    else $error("overcurrent code wrong");

  AST_LOW_SPD_OL: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (mode != TCCO_MODE_OFF && cause_q == 7'h26) |-> enc_code == 4'h2)
    else $error("low-speed overload code wrong");

  AST_OV: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (mode != TCCO_MODE_OFF && cause_q == 7'h0f) |-> enc_code == 4'h3)
    else $error("overvoltage code wrong");

  AST_PWR_FAIL: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (mode != TCCO_MODE_OFF && cause_q == 7'h10) |-> enc_code == 4'h5)
    else $error("power failure code wrong");

  AST_SW_ERR: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (mode != TCCO_MODE_OFF && cause_q == 7'h1e) |-> enc_code == 4'h6)
    else $error("switch error code wrong");

  AST_4BIT_HW: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (mode == TCCO_MODE_4BIT && cause_q == 7'h17) |-> enc_code == 4'h8)
    else $error("hardware error code wrong");

  AST_4BIT_SENSOR: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (mode == TCCO_MODE_4BIT && cause_q == 7'h0a) |-> enc_code == 4'h9)
    else $error("sensor error code wrong");

  AST_4BIT_EXT: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (mode == TCCO_MODE_4BIT && cause_q == 7'h24) |-> enc_code == 4'ha)
    else $error("external trip code wrong");

  AST_4BIT_GND: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (mode == TCCO_MODE_4BIT && cause_q == 7'h0e) |-> enc_code == 4'hb)
    else $error("ground fault code wrong");

  AST_4BIT_SEQ: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (mode == TCCO_MODE_4BIT && cause_q == 7'h2c) |-> enc_code == 4'hc)
    else $error("sequence fault code wrong");

  AST_4BIT_TEMP: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (mode == TCCO_MODE_4BIT && cause_q == 7'h14) |-> enc_code == 4'hd)
    else $error("over-temperature code wrong");

  AST_3BIT_USER: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (mode == TCCO_MODE_3BIT && cause_q == 7'h40) |-> enc_code == 4'h7)
    else $error("3-bit user trip code wrong");

  AST_OFF_ZERO: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (mode == TCCO_MODE_OFF) |-> enc_code == 4'h0)
    else $error("code produced while output off");

  AST_MODE_DEC: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (width_sel_q > `TCCO_SEL_4BIT) |-> mode == TCCO_MODE_OFF)
    else $error("unknown select not treated as off");

  AST_TRIP_LATCH: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (tripped_q && !clear_ev) |=> cause_q == $past(cause_q))
    else $error("latched cause overwritten");

  AST_TRIP_CAUSE: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    trip_ev |=> tripped_q && cause_q == $past(trip_cause_in))
    else $error("trip cause not latched");

  sequence s_clear_done;
    clear_ev ##1 !tripped_q;
  endsequence

  AST_CLEAR_ZERO: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    s_clear_done |=> code_q == 4'h0)
    else $error("code not zero after clear");

  sequence s_idle_4bit;
    (mode == TCCO_MODE_4BIT && !tripped_q) [*3];
  endsequence

  AST_4BIT_IDLE_TERM: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    s_idle_4bit |=> term_out[3:0] == 4'h0)
    else $error("terminals nonzero with no trip");
endmodule

// >>> tb/tcco_reader.sv
// Far-side controller that reads the trip code off the output terminals.
// Assumes it is told which code width the drive was set to.
module tcco_reader (
  input wire logic clk_in,
  input wire logic [1:0] width_in,
  input wire logic [4:0] term_in,
  output logic [3:0] code_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Terminal 11 is taken as the least significant bit
  always @(posedge clk_in) begin
    code_out <= (width_in == 2'h2) ? term_in[3:0] :
                (width_in == 2'h1) ? {1'b0, term_in[2:0]} : 4'h0;
  end
endmodule

// >>> tb/tcco_top_tb_top.sv
// Self-checking bench for the trip cause code output block.
// Assumes the package and constants header are compiled first.
`include "tcco_consts.svh"

module tcco_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_in, sys_rst_in, wb_cyc_in, wb_stb_in, wb_we_in;
  logic [3:0] wb_adr_in, wb_sel_in, seen;
  logic [31:0] wb_dat_in, wb_dat_out, rd;
  logic wb_ack_out, trip_in, trip_reset_in, irq_out;
  logic [`TCCO_CAUSE_W-1:0] trip_cause_in;
  logic [4:0] term_func_in, term_out;
  logic [1:0] width;
  logic [15:0] lfsr = 16'h002a;
  int num_errors = 0;
  int checks = 0;
  int cyc_n = 0;

  tcco_top DUT (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
    .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .trip_in(trip_in),
    .trip_cause_in(trip_cause_in), .trip_reset_in(trip_reset_in),
    .term_func_in(term_func_in), .term_out(term_out), .irq_out(irq_out));
  tcco_reader reader (.clk_in(clk_sys_in), .width_in(width),
    .term_in(term_out), .code_out(seen));

  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  // ********************************
  // Helpers and reference model
  // ********************************
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  function automatic int model(int c, int m);
    int k;
    case (c)
      1, 2, 3, 4: k = 1;
      5, 38: k = 2;
      7, 15: k = 3;
      9: k = 4;
      16: k = 5;
      30: k = 6;
      6: k = 7;
      8, 11, 23, 25: k = 8;
      10: k = 9;
      12, 13, 35, 36: k = 10;
      14: k = 11;
      43, 44, 45: k = 12;
      20, 21: k = 13;
      24: k = 14;
      default: k = (c >= 50 && c <= 79) ? 15 : 0;
    endcase
    if (m == 1 && (k > 6 || (k == 0 && c != 0))) k = 7;
    if (m != 1 && m != 2) k = 0;
    return k;
  endfunction

  function automatic logic [4:0] exp_term(int k, int m, logic [4:0] f);
    logic [4:0] t;
    t = (m == 2) ? {f[4], 4'(k)} : (m == 1) ? {f[4:3], 3'(k)} : f;
    return t;
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic wb(input logic we, input logic [3:0] a,
                    input logic [3:0] sl, input logic [31:0] d);
    @(posedge clk_sys_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= we;
    wb_adr_in <= a;
    wb_sel_in <= sl;
    wb_dat_in <= d;
    do @(posedge clk_sys_in); while (wb_ack_out !== 1'b1);
    rd = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    wb_we_in <= 1'b0;
  endtask

  // Trip, try a second trip while held, then clear and see a zero code, or the plain terminal functions when off
  task automatic trip(int c, int m);
    logic [4:0] f;
    f = 5'(rnd());
    @(posedge clk_sys_in);
    trip_cause_in <= c[6:0];
    trip_in <= 1'b1;
    term_func_in <= f;
    @(posedge clk_sys_in);
    trip_in <= 1'b0;
    trip_cause_in <= 7'(rnd());
    repeat (6) @(posedge clk_sys_in);
    chk(term_out, exp_term(model(c, m), m, f));
    chk(seen, model(c, m));
    wb(1'b0, 4'h4, 4'hf, 32'h0);
    chk(rd, model(c, m));
    trip_in <= 1'b1;
    @(posedge clk_sys_in);
    trip_in <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    chk(term_out, exp_term(model(c, m), m, f));
    trip_reset_in <= 1'b1;
    @(posedge clk_sys_in);
    trip_reset_in <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    chk(term_out, exp_term(0, m, f));
  endtask

  task final_report;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Run ceiling sized well above three modes of 128 trips each
  always @(posedge clk_sys_in) begin
    cyc_n++;
    if (cyc_n == 40000) begin
      num_errors++;
      final_report;
    end
  end

  // ********************************
  // Main sequence
  // ********************************
  initial begin
    {wb_cyc_in, wb_stb_in, wb_we_in, trip_in, trip_reset_in} = 5'h00;
    {wb_adr_in, wb_sel_in, wb_dat_in} = 40'h0;
    trip_cause_in = 7'h00;
    term_func_in = 5'h00;
    width = 2'h0;
    sys_rst_in = 1'b1;
    repeat (2) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    wb(1'b0, 4'h0, 4'hf, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, 4'h0, 4'h0, 32'h2);
    wb(1'b0, 4'h0, 4'hf, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, 4'h6, 4'hf, 32'hff);
    wb(1'b0, 4'h6, 4'hf, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, 4'h3, 4'hf, 32'h1);
    trip(3, 0);
    @(posedge clk_sys_in);
    chk(irq_out, 1'b1);
    wb(1'b0, 4'h2, 4'hf, 32'h0);
    chk(rd, 32'h3);
    wb(1'b1, 4'h3, 4'hf, 32'h0);
    @(posedge clk_sys_in);
    chk(irq_out, 1'b0);
    wb(1'b1, 4'h2, 4'hf, 32'h3);
    wb(1'b1, 4'h3, 4'hf, 32'h3);
    @(posedge clk_sys_in);
    chk(irq_out, 1'b0);
    for (int m = 1; m <= 3; m++) begin
      wb(1'b1, 4'h0, 4'hf, 32'(m));
      width = 2'(m);
      for (int c = 0; c < 128; c++) trip(c, m);
    end
    // Reset mid-run while tripped: select back to off, code cleared
    wb(1'b1, 4'h0, 4'hf, 32'h2);
    trip_cause_in <= 7'h06;
    trip_in <= 1'b1;
    @(posedge clk_sys_in);
    trip_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    chk(term_out[3:0], 4'h7);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    wb(1'b0, 4'h0, 4'hf, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, 4'h4, 4'hf, 32'h0);
    chk(rd, 32'h0);
    chk(term_out, term_func_in);
    final_report;
  end
endmodule
